// ### core/fwg_pkg.sv
package fwg_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   // 512-byte pages
   localparam int PAGE_SHIFT = 9;
   localparam logic [ADDR_W-1:0] PAGE0_FIRST = 13'h0000;
   localparam logic [ADDR_W-1:0] PAGE0_LAST = 13'h01ff;
   // program store control field positions and reset
   localparam int PSC_WE_BIT = 0;
   localparam int PSC_EE_BIT = 1;
   localparam logic [7:0] PSC_RESET = 8'h00;
   localparam logic [DATA_W-1:0] LOCK_ERASED = 8'hff;
   localparam int BUSY_CYCLES = 4;
   typedef enum logic [1:0] {
      FWG_OP_READ,
      FWG_OP_WRITE,
      FWG_OP_ERASE,
      FWG_OP_XREAD
   } fwg_op_t;
   typedef enum logic [1:0] {
      FWG_SRC_CORE_UNPROT,
      FWG_SRC_CORE_PROT,
      FWG_SRC_DEBUG
   } fwg_src_t;
endpackage

// ### core/fwg_lock_check.sv
module fwg_lock_check #(
   parameter int ADDR_W = 13,
   parameter int DATA_W = 8
) (
   // lock state
   input wire logic [DATA_W-1:0] lock_byte,
   input wire logic [ADDR_W-1:0] lock_byte_addr,
   // access
   input wire logic [ADDR_W-1:0] addr,
   input wire logic guarded_src,
   // verdict
   output logic locked
);
   import fwg_pkg::*;
   logic [DATA_W-1:0] n_pages;
   logic [ADDR_W-1:0] page;
   logic on_lock_page;
   always_comb begin
      n_pages = ~lock_byte; // R5
      page = addr >> PAGE_SHIFT; // R12
      on_lock_page = (page == (lock_byte_addr >> PAGE_SHIFT));
      locked = 1'b0;
      if (guarded_src) begin
         if (ADDR_W'(n_pages) > page) locked = 1'b1; // R5
         if (on_lock_page && lock_byte != LOCK_ERASED) locked = 1'b1; // R6
      end
   end
endmodule

// ### core/fwg_guard.sv
// What this block does (R1-R8, R12) and what software must do (R9-R11)
// R1: no flash write unless write enable set
// R2: erase needs write and erase enables
// R3: write enable sits in control bit 0
// R4: lock byte blocks unprotected and debug access
// R5: lock inverted-count pages from page 0
// R6: lock byte page locked if any zero
// R7: data moves write, code moves read flash
// R8: hold interrupts pending during flash operation
// R9: software disables interrupts around write enable
// R10: software arms supply monitor before operation
// R11: software checks flash address bounds
// R12: page number compared against lock count
module fwg_guard
   import fwg_pkg::*;
#(
   parameter int ADDR_W = fwg_pkg::ADDR_W,
   parameter int DATA_W = fwg_pkg::DATA_W,
   parameter logic [ADDR_W-1:0] LOCK_ADDR = 13'h1fff,
   parameter int BUSY = fwg_pkg::BUSY_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // control register write port
   input wire logic psc_wr,
   input wire logic [7:0] psc_wdata,
   output logic [7:0] program_store_control,
   // lock byte as read from flash
   input wire logic [DATA_W-1:0] lock_byte,
   // access request
   input wire logic req,
   input wire fwg_pkg::fwg_op_t req_op,
   input wire fwg_pkg::fwg_src_t req_src,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic req_denied,
   // flash array side
   output logic flash_rd,
   output logic flash_wr,
   output logic flash_erase,
   output logic [ADDR_W-1:0] flash_addr,
   output logic [DATA_W-1:0] flash_wdata,
   input wire logic flash_done,
   // external data ram side
   output logic external_data_ram_rd,
   // interrupt hold
   input wire logic irq_in,
   output logic irq_hold,
   output logic irq_pending
);
   import fwg_pkg::*;
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      FWG_IDLE,
      FWG_BUSY
   } fwg_state_t;
   fwg_state_t state;
   logic locked;
   logic allowed;
   logic is_mod;
   logic [$clog2(BUSY+1)-1:0] busy_cnt;
   fwg_lock_check #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_lock (
      .lock_byte(lock_byte),
      .lock_byte_addr(LOCK_ADDR),
      .addr(req_addr),
      .guarded_src(req_src != FWG_SRC_CORE_PROT), // R4 R12
      .locked(locked)
   );
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         program_store_control <= PSC_RESET;
      end else if (clk_en && psc_wr) begin
         // only the two enable bits exist; others read zero
         program_store_control <= 8'h00;
         program_store_control[PSC_WE_BIT] <= psc_wdata[PSC_WE_BIT]; // R3
         program_store_control[PSC_EE_BIT] <= psc_wdata[PSC_EE_BIT];
      end
   end
   ////////////////////////////////////////////////////////////////////
   always_comb begin
      is_mod = (req_op == FWG_OP_WRITE) || (req_op == FWG_OP_ERASE);
      allowed = 1'b1;
      unique case (req_op)
         FWG_OP_READ: allowed = !locked; // R4
         FWG_OP_WRITE: allowed = !locked && program_store_control[PSC_WE_BIT]; // R1
         FWG_OP_ERASE: allowed = !locked && program_store_control[PSC_WE_BIT]
            && program_store_control[PSC_EE_BIT]; // R2
         FWG_OP_XREAD: allowed = 1'b1; // R7
      endcase
      req_ready = (state == FWG_IDLE);
   end
   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= FWG_IDLE;
         busy_cnt <= '0;
         flash_rd <= 1'b0;
         flash_wr <= 1'b0;
         flash_erase <= 1'b0;
         external_data_ram_rd <= 1'b0;
         req_denied <= 1'b0;
         flash_addr <= '0;
         flash_wdata <= '0;
      end else if (clk_en) begin
         flash_rd <= 1'b0;
         flash_wr <= 1'b0;
         flash_erase <= 1'b0;
         external_data_ram_rd <= 1'b0;
         req_denied <= 1'b0;
         unique case (state)
            FWG_IDLE: if (req) begin
               flash_addr <= req_addr;
               flash_wdata <= req_wdata;
               if (!allowed) begin
                  req_denied <= 1'b1; // R1 R2 R4
               end else if (req_op == FWG_OP_XREAD) begin
                  external_data_ram_rd <= 1'b1; // R7
               end else if (req_op == FWG_OP_READ) begin
                  flash_rd <= 1'b1; // R7
               end else begin
                  flash_wr <= (req_op == FWG_OP_WRITE);
                  flash_erase <= (req_op == FWG_OP_ERASE);
                  busy_cnt <= '0;
                  state <= FWG_BUSY;
               end
            end
            FWG_BUSY: begin
               // a floor on busy time: flash_done is ignored until busy_cnt reaches BUSY
               if (busy_cnt < BUSY) busy_cnt <= busy_cnt + 1'b1;
               else if (flash_done) state <= FWG_IDLE;
            end
            default: state <= FWG_IDLE;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////////////
   assign irq_hold = (state == FWG_BUSY); // R8
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_pending <= 1'b0;
      end else if (clk_en) begin
         // set needs hold: pending clears once hold drops, and a pulse then is not latched
         if (irq_in && irq_hold) irq_pending <= 1'b1; // R8
         else if (!irq_hold) irq_pending <= 1'b0;
      end
   end
endmodule

// ### dv/fwg_flash_model.sv
module fwg_flash_model (
   input wire logic clk, rst_b, flash_wr, flash_erase,
   input wire logic [3:0] slow,
   output logic flash_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] cnt;
   // done never early: array time is floor plus a random stall
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) cnt <= '0;
      else if (flash_wr || flash_erase) cnt <= 5'h6 + slow;
      else if (cnt != 5'h0) cnt <= cnt - 5'h1;
   end
   assign flash_done = cnt == 5'h1;
endmodule

// ### dv/fwg_guard_assertions.sv
module fwg_guard_chk
   import fwg_pkg::*;
(
   input wire logic clk, rst_b, clk_en, psc_wr, req, req_ready, req_denied, flash_rd,
   input wire logic flash_wr, flash_erase, external_data_ram_rd, irq_in, irq_hold, irq_pending,
   input wire logic [7:0] psc_wdata, program_store_control, lock_byte,
   input wire fwg_pkg::fwg_op_t req_op,
   input wire fwg_pkg::fwg_src_t req_src,
   input wire logic [12:0] req_addr
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire tk = clk_en && req && req_ready;
   wire unp = req_src != FWG_SRC_CORE_PROT;
   wire fl = req_op != FWG_OP_XREAD;
   sequence s_busy;
      !req_ready [*5];
   endsequence
   a_write_needs_we: assert property (tk && req_op == FWG_OP_WRITE && !program_store_control[0]
      |=> req_denied && !flash_wr) else $error("bad write");
   a_erase_needs_both: assert property (tk && req_op == FWG_OP_ERASE &&
      program_store_control[1:0] != 2'h3 |=> req_denied && !flash_erase) else $error("bad erase");
   a_psc_we_bit: assert property (clk_en && psc_wr
      |=> program_store_control == ($past(psc_wdata) & 8'h03)) else $error("psc");
   a_prot_exempt: assert property (tk && !unp && req_op == FWG_OP_READ
      |=> flash_rd) else $error("prot read");
   a_lock_count: assert property (tk && unp && fl && {4'h0, req_addr[12:9]} < ~lock_byte
      |=> req_denied) else $error("lock count");
   a_lock_page: assert property (tk && unp && fl && req_addr[12:9] == 4'hf && lock_byte != 8'hff
      |=> req_denied) else $error("lock page");
   a_xread_to_ram: assert property (tk && !fl |=> external_data_ram_rd && !flash_rd) else $error("xread");
   a_busy_floor: assert property ($rose(irq_hold) |-> s_busy) else $error("busy");
   a_irq_held: assert property (clk_en && irq_hold && irq_in |=> irq_pending) else $error("irq");
   a_freeze_psc: assert property (!clk_en |=> $stable(program_store_control)) else $error("frz");
endmodule
bind fwg_guard fwg_guard_chk fwg_guard_chk_inst (.*);

// ### dv/testbench.sv
module testbench
   import fwg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, clk_en, psc_wr, req, req_ready, req_denied, flash_rd, flash_wr;
   logic flash_erase, flash_done, external_data_ram_rd, irq_in, irq_hold, irq_pending;
   logic [7:0] psc_wdata, program_store_control, lock_byte, req_wdata, flash_wdata;
   logic [12:0] req_addr, flash_addr;
   logic [3:0] slow;
   fwg_op_t req_op;
   fwg_src_t req_src;
   int failures, n_checks;
   fwg_guard fwg_guard_inst (.*);
   fwg_flash_model fwg_flash_model_inst (.*);
   task conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [12:0] s, e);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask
   // only protected code skips the page check
   function logic [4:0] exp_res(fwg_op_t o, fwg_src_t s, logic [12:0] a, logic [7:0] p, lb);
      logic lk;
      lk = s != FWG_SRC_CORE_PROT && ({4'h0, a[12:9]} < ~lb || (a[12:9] == 4'hf && lb != 8'hff));
      if (o == FWG_OP_XREAD) return 5'h08;
      if (lk || (o == FWG_OP_WRITE && !p[0]) || (o == FWG_OP_ERASE && p[1:0] != 2'h3)) return 5'h10;
      return o == FWG_OP_READ ? 5'h01 : o == FWG_OP_WRITE ? 5'h02 : 5'h04;
   endfunction
   task setp(input logic [7:0] v);
      psc_wr = 1;
      psc_wdata = v;
      @(posedge clk) #1 psc_wr = 0;
      chk("psc", program_store_control, v & 8'h03);
   endtask
   task acc(input fwg_op_t o, input fwg_src_t s, input logic [12:0] a);
      int n;
      req = 1;
      {req_op, req_src, req_addr, req_wdata, slow} = {o, s, a, 8'($urandom), 4'($urandom)};
      @(posedge clk) #1 req = 0;
      chk("result", {req_denied, external_data_ram_rd, flash_erase, flash_wr, flash_rd},
         exp_res(o, s, a, program_store_control, lock_byte));
      chk("addr", flash_addr, a);
      chk("wdata", flash_wdata, req_wdata);
      // irq noise while busy exercises the hold path
      for (n = 0; n < 40 && req_ready !== 1'b1; n++) begin
         irq_in = 1'($urandom);
         @(posedge clk) #1;
      end
      irq_in = 0;
      if (n == 40) begin
         failures++;
         conclude();
      end
   endtask
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   initial begin
      {rst_b, clk_en, psc_wr, psc_wdata, lock_byte, req, req_addr, req_wdata, irq_in, slow} = '0;
      req_op = FWG_OP_READ;
      req_src = FWG_SRC_CORE_PROT;
      void'($urandom(91603));
      repeat (5) @(posedge clk);
      #1 {rst_b, clk_en, lock_byte} = {2'h3, 8'hff};
      chk("psc0", program_store_control, 8'h00);
      chk("ready", req_ready, 1'b1);
      for (int i = 0; i < 16; i++) begin
         setp(8'(i));
         acc(fwg_op_t'(i[3:2]), FWG_SRC_CORE_UNPROT, 13'($urandom));
      end
      // a frozen clock enable must keep the control register as it was
      clk_en = 0;
      psc_wr = 1;
      psc_wdata = 8'h00;
      @(posedge clk) #1 psc_wr = 0;
      clk_en = 1;
      chk("freeze", program_store_control, 8'h03);
      setp(8'hff);
      for (int i = 0; i < 40; i++) begin
         lock_byte = i < 9 ? 8'hfd : 8'($urandom);
         acc(fwg_op_t'($urandom % 3), fwg_src_t'($urandom % 3),
            i < 8 ? 13'(i * 256) : i == 8 ? 13'h1fff : 13'($urandom));
      end
      setp(8'h00);
      conclude();
   end
endmodule
